// ---- hdl/flash_status_poll.sv ----
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Purpose: host-side toggle/timeout status poller for a parallel flash
// Assumes: flash started its operation through the same pins already
// Notes: start runs the toggle algorithm at the address register
module flash_status_poll
  import flash_poll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [ADDR_W-1:0] fl_addr_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  input wire logic [DATA_W-1:0] fl_dq_i,
  output logic [DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o,
  input wire logic ready_busy_in_i
);
  typedef enum logic [3:0] {
    S_IDLE, S_READ1, S_READ2, S_CMP, S_READ3, S_RECHK, S_RESET,
    S_DATA, S_WIN
  } poll_state_t;
  poll_state_t state_q;
  logic [DATA_W-1:0] first_q;
  logic [DATA_W-1:0] last_q;
  logic busy_q, done_q, fail_q, win_q, susp_q, sect_q;
  logic req_q, wr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [ADDR_W-1:0] addr_reg;
  logic [3:0] ctrl;
  logic ctrl_wr;
  logic [31:0] stat;
  flash_cyc_if cyc ();

  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  // status reads always use the programmed busy-bank address [R17] [R18]
  assign cyc.addr = addr_reg;
  assign cyc.wdata = wdata_q;

  wire go = ctrl_wr && ctrl[CTRL_START];
  wire do_reset = ctrl_wr && ctrl[CTRL_RESET];
  wire do_window = ctrl_wr && ctrl[CTRL_WINDOW];
  wire single = ctrl[CTRL_SINGLE];
  wire [DATA_W-1:0] rd = cyc.rdata;
  // toggle status decides busy; sector toggle locates the sector [R3]
  wire tog_moved = first_q[BIT_TOGGLE] != rd[BIT_TOGGLE]; // [R4]
  wire sec_moved = first_q[BIT_SECTOR] != rd[BIT_SECTOR];
  wire tmo_seen = rd[BIT_TIMEOUT]; // [R9]
  wire rdy = ready_busy_in_i;

  assign stat = {26'h0, sect_q, susp_q, win_q, fail_q, done_q, busy_q};

  flash_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .stat_i(stat),
    .data_i(last_q),
    .addr_o(addr_reg),
    .ctrl_o(ctrl),
    .ctrl_wr_o(ctrl_wr)
  );

  flash_pin_cycle u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc(cyc),
    .fl_addr_o(fl_addr_o),
    .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o),
    .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      first_q <= '0;
      last_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      win_q <= 1'b0;
      susp_q <= 1'b0;
      sect_q <= 1'b0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (do_reset) begin
            wr_q <= 1'b1;
            wdata_q <= CMD_RESET;
            req_q <= 1'b1;
            busy_q <= 1'b1;
            state_q <= S_RESET;
          end else if (go || do_window) begin
            // a start is a fresh double read, a window request a single read [R8] [R4]
            wr_q <= 1'b0;
            req_q <= 1'b1;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            state_q <= do_window ? S_WIN : S_READ1;
          end
        end
        S_WIN: begin
          // window bit before/after each added sector erase [R16] [R13]
          if (cyc.done) begin
            req_q <= 1'b0;
            win_q <= rd[BIT_WINDOW]; // [R12] [R14] [R15]
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_READ1: begin
          if (cyc.done) begin
            first_q <= rd;
            state_q <= S_READ2;
          end
        end
        S_READ2: begin
          if (cyc.done) begin
            req_q <= 1'b0;
            last_q <= rd;
            sect_q <= sec_moved; // [R2] [R3]
            // steady toggle bit with sector toggle moving and ready: suspended
            susp_q <= !tog_moved && sec_moved && rdy; // [R23]
            state_q <= S_CMP;
          end
        end
        S_CMP: begin
          if (!tog_moved_q()) begin
            // finished: next read gives array data [R5] [R19]
            req_q <= 1'b1;
            state_q <= S_DATA;
          end else if (last_q[BIT_TIMEOUT]) begin
            first_q <= last_q; // [R6]
            req_q <= 1'b1;
            state_q <= S_READ3;
          end else if (single) begin
            // give the bus back; next start restarts [R8]
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            // still running normally, timeout flag low [R24] [R22]
            req_q <= 1'b1;
            state_q <= S_READ1;
          end
        end
        S_READ3: begin
          if (cyc.done) begin
            if (tog_moved) begin
              // failure, includes program of one over zero [R7] [R10]
              fail_q <= 1'b1;
              wr_q <= 1'b1;
              wdata_q <= CMD_RESET;
              state_q <= S_RESET; // [R11]
            end else begin
              state_q <= S_DATA;
            end
          end
        end
        S_DATA: begin
          if (cyc.done) begin
            req_q <= 1'b0;
            last_q <= rd; // [R20] [R21] [R1]
            done_q <= !fail_q;
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_RESET: begin
          if (cyc.done) begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  function automatic logic tog_moved_q();
    tog_moved_q = first_q[BIT_TOGGLE] != last_q[BIT_TOGGLE];
  endfunction

  a_fail_resets: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fail_q) |-> state_q == S_RESET && wr_q) // [R7]
    else $error("failure did not issue reset command");
  a_reset_data: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_RESET |-> wdata_q == CMD_RESET) // [R11]
    else $error("reset cycle carries wrong command");
  a_recheck_tmo: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CMP && tog_moved_q() && last_q[BIT_TIMEOUT]
    |=> state_q == S_READ3) // [R6]
    else $error("timeout flag not rechecked");
  a_two_reads: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_IDLE && go && !do_reset && !do_window
    |=> state_q == S_READ1) // [R8]
    else $error("poll did not restart with double read");
  a_data_after: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CMP && !tog_moved_q() |=> state_q == S_DATA) // [R5]
    else $error("no data read after steady toggle");
  a_steady_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_q) |-> !fail_q) // [R4]
    else $error("done and fail together");
  a_addr_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    fl_oe_n_o == 1'b0 |-> fl_addr_o == $past(addr_reg)) // [R17]
    else $error("status read at wrong address");
  a_cmp_reads: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_READ2 && cyc.done |=> state_q == S_CMP) // [R4]
    else $error("second read not compared");
endmodule

// ---- hdl/flash_poll_pkg.sv ----
// Purpose: shared constants for the flash write-status poll controller
// Assumes: 16-bit flash data bus, 10 MHz system clock
// Notes: Summary of operation
// Summary of operation
// R1 - status valid after final write strobe
// R2 - sector toggle bit flips per erased-sector read
// R3 - host combines sector toggle and toggle status
// R4 - host does two back-to-back reads, compares
// R5 - finished operation stops toggling, returns data
// R6 - still toggling: check timeout flag, recheck
// R7 - toggling after timeout recheck means failure, reset
// R8 - resumed polling restarts from first double read
// R9 - timeout flag high on pulse limit exceeded
// R10 - programming one over zero ends in timeout
// R11 - after timeout failure host writes reset command
// R12 - erase window bit zero during acceptance timeout
// R13 - host may skip window check if spaced
// R14 - window bit one: only suspend accepted
// R15 - window bit zero: more sector erases accepted
// R16 - host checks window before and after add
// R17 - host addresses busy bank for status
// R18 - host supplies valid operation address for status
// R19 - toggle status flips every read while busy
// R20 - completion poll shows complement while programming
// R21 - completion poll zero in erase, one after
// R22 - ready busy low while programming or erasing
// R23 - suspended sector read shows poll one, steady
// R24 - timeout flag zero while operations run normally
package flash_poll_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [3:0] BIT_POLL = 4'h7;
  localparam logic [3:0] BIT_TOGGLE = 4'h6;
  localparam logic [3:0] BIT_TIMEOUT = 4'h5;
  localparam logic [3:0] BIT_WINDOW = 4'h3;
  localparam logic [3:0] BIT_SECTOR = 4'h2;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  // read/write cycle: access ns rounded up to clocks; strobe held low ACC_CNT+1 clocks
  localparam int ACC_NS = 100;
  localparam int CLK_NS = 100;
  localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ACC_CNT = 4'(ACC_CYC + 1);
  // wishbone register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hC;
  localparam int CTRL_START = 0;
  localparam int CTRL_RESET = 1;
  localparam int CTRL_WINDOW = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_WINDOW = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_SECTOR = 5;
endpackage

// ---- hdl/flash_cyc_if.sv ----
`timescale 1ns/1ps
// Purpose: request/answer link between sequencer and pin cycle engine
// Assumes: single clock
// Notes: req is a level held until done pulses
interface flash_cyc_if;
  import flash_poll_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic done;
  modport master (output req, output wr, output addr, output wdata,
    input rdata, input done);
  modport engine (input req, input wr, input addr, input wdata,
    output rdata, output done);
endinterface

// ---- hdl/flash_pin_cycle.sv ----
`timescale 1ns/1ps
// Purpose: one asynchronous flash read or write cycle on the pins
// Assumes: flash data pins synchronous to clk_i
// Notes: each read is a separate oe frame so toggle bits advance
module flash_pin_cycle
  import flash_poll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  flash_cyc_if.engine cyc,
  output logic [ADDR_W-1:0] fl_addr_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  input wire logic [DATA_W-1:0] fl_dq_i,
  output logic [DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o
);
  typedef enum logic [1:0] {C_IDLE, C_STROBE, C_GAP} cyc_state_t;
  cyc_state_t state_q;
  logic [3:0] cnt_q;
  logic [DATA_W-1:0] rdata_q;
  logic done_q;
  wire cnt_zero = (cnt_q == 4'h0);
  assign cyc.rdata = rdata_q;
  assign cyc.done = done_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= C_IDLE;
      cnt_q <= 4'h0;
      rdata_q <= '0;
      done_q <= 1'b0;
      fl_addr_o <= '0;
      fl_ce_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_dq_o <= '0;
      fl_dq_oe_o <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        C_IDLE: begin
          if (cyc.req && !done_q) begin
            fl_addr_o <= cyc.addr;
            fl_ce_n_o <= 1'b0;
            fl_oe_n_o <= cyc.wr;
            fl_we_n_o <= !cyc.wr;
            fl_dq_o <= cyc.wdata;
            fl_dq_oe_o <= cyc.wr;
            cnt_q <= ACC_CNT;
            state_q <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (cnt_zero) begin
            rdata_q <= fl_dq_i;
            fl_oe_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            state_q <= C_GAP;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        C_GAP: begin
          // one idle cycle keeps dq driven past the we rising edge
          fl_dq_oe_o <= 1'b0;
          done_q <= 1'b1;
          state_q <= C_IDLE;
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end
endmodule

// ---- hdl/flash_wb_regs.sv ----
`timescale 1ns/1ps
// Purpose: classic wishbone slave holding control and address words, reading status
// Assumes: 32-bit data, byte addresses, word aligned
// Notes: answers in the cycle after stb, unmapped reads zero
module flash_wb_regs
  import flash_poll_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] stat_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [3:0] ctrl_o,
  output logic ctrl_wr_o
);
  wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_ctrl = access && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];
  wire wr_addr = access && wb_we_i && wb_adr_i == REG_ADDR;
  logic [31:0] rd_mux;
  assign rd_mux = (wb_adr_i == REG_ADDR) ? 32'(addr_o) :
                  (wb_adr_i == REG_STAT) ? stat_i :
                  (wb_adr_i == REG_DATA) ? 32'(data_i) : 32'h0000_0000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      addr_o <= '0;
      ctrl_o <= 4'h0;
      ctrl_wr_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= rd_mux;
      ctrl_wr_o <= wr_ctrl;
      if (wr_ctrl) ctrl_o <= wb_dat_i[3:0];
      if (wr_addr) addr_o <= wb_dat_i[ADDR_W-1:0];
    end
  end
endmodule

// ---- bench/flash_dev_model.sv ----
// Purpose: behavioural flash status source for the poll controller bench
// Assumes: bench loads the mode; a read frame is ce and oe both low
// Notes: modes 0 idle,1 program,2 erase,3 program fault,4 suspended,
//   5 erase still taking sectors
`timescale 1ns/1ps
module flash_dev_model
  import flash_poll_pkg::*;
#(
  parameter logic [2:0] BANK = 3'h2,
  parameter logic [15:0] ARRAY = 16'h5A3C
)(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic ready_busy_o,
  input wire logic load_i,
  input wire logic [2:0] mode_i,
  input wire logic [7:0] finish_i
);
  logic [2:0] mode = 3'h0;
  logic [7:0] left = 8'h00;
  logic tog = 1'b0;
  logic tog2 = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] word;
  wire rd = !ce_n_i && !oe_n_i;
  wire in_bank = addr_i[21:19] == BANK;
  wire busy = mode inside {3'h1, 3'h2, 3'h3, 3'h5};
  wire erase = mode inside {3'h2, 3'h4, 3'h5};
  always_comb begin
    word = ARRAY;
    if (mode != 3'h0 && in_bank) begin
      word[7] = (mode == 3'h4) ? 1'b1 : erase ? 1'b0 : ~ARRAY[7];
      word[6] = tog;
      word[5] = mode == 3'h3;
      word[3] = mode == 3'h2;
      word[2] = erase ? tog2 : 1'b0;
    end
  end
  // a released bus shows the inverse of the last word, never a held value
  assign dq_o = rd ? word : ~last;
  assign ready_busy_o = !busy;
  always @(posedge load_i) begin
    mode = mode_i;
    left = finish_i;
  end
  always @(negedge rd) begin
    last = word;
    if (busy) tog = ~tog;
    if (erase && in_bank) tog2 = ~tog2;
    if ((mode == 3'h1 || mode == 3'h2) && left != 8'hFF) begin
      if (left == 8'h00) mode = 3'h0;
      else left = left - 8'h01;
    end
  end
  // a running erase ignores the reset word; only the fault leaves on it
  always @(posedge we_n_i) begin
    if (mode == 3'h3 && dq_i == CMD_RESET) mode = 3'h0;
  end
endmodule

// ---- bench/tb_flash_status_poll.sv ----
// Purpose: self-checking bench for the flash status poll controller
// Assumes: device model on the flash pins, wishbone driven from here
// Notes: polls, window reads and the fault reset come from the row table, one mid-poll reset follows
`timescale 1ns/1ps
module tb_flash_status_poll
  import flash_poll_pkg::*;
;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] fin;
    logic far;
    logic [3:0] ctrl;
    logic [5:0] mask;
    logic [5:0] exp;
  } row_t;
  localparam logic [15:0] ARRAY = 16'h5A3C;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [ADDR_W-1:0] fl_addr_o;
  logic fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o, rb;
  logic [DATA_W-1:0] fl_dq_o, dev_dq, dq_bus;
  logic load = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] fin = 8'h00;
  logic [31:0] q;
  int n_mismatch = 0;
  int samples_checked = 0;
  row_t rows [9];
  assign dq_bus = fl_dq_oe_o ? fl_dq_o : dev_dq;
  flash_status_poll dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o),
    .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
    .fl_dq_i(dq_bus), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
    .ready_busy_in_i(rb));
  flash_dev_model #(.ARRAY(ARRAY)) dev_u (.addr_i(fl_addr_o),
    .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
    .dq_i(dq_bus), .dq_o(dev_dq), .ready_busy_o(rb), .load_i(load),
    .mode_i(mode), .finish_i(fin));
  initial forever #50 clk_i = ~clk_i;
  task automatic results();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
    results();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // called just after an edge; holds the request until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) hang();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic poll_end();
    int n;
    n = 0;
    do begin
      wb(REG_STAT, 1'b0, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) hang();
  endtask
  task automatic run(input logic [2:0] m, input logic [7:0] f,
                     input logic far, input logic [3:0] c);
    mode <= m;
    fin <= f;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    wb(REG_ADDR, 1'b1, far ? 32'h0000_0040 : 32'h0010_0040);
    wb(REG_CTRL, 1'b1, {28'h0, c});
  endtask
  initial begin
    rows[0] = '{3'h0, 8'hFF, 1'b0, 4'h1, 6'h06, 6'h02};
    rows[1] = '{3'h1, 8'h03, 1'b0, 4'h1, 6'h06, 6'h02};
    rows[2] = '{3'h2, 8'h05, 1'b0, 4'h1, 6'h06, 6'h02};
    rows[3] = '{3'h1, 8'hFF, 1'b1, 4'h1, 6'h06, 6'h02};
    rows[4] = '{3'h2, 8'hFF, 1'b0, 4'h4, 6'h08, 6'h08};
    rows[5] = '{3'h5, 8'hFF, 1'b0, 4'h4, 6'h08, 6'h00};
    rows[6] = '{3'h4, 8'hFF, 1'b0, 4'h1, 6'h30, 6'h30};
    rows[7] = '{3'h2, 8'hFF, 1'b0, 4'h9, 6'h06, 6'h00};
    rows[8] = '{3'h3, 8'hFF, 1'b0, 4'h1, 6'h06, 6'h04};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o}, 32'hE);
    wb(4'h2, 1'b0, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 9; i++) begin
      run(rows[i].mode, rows[i].fin, rows[i].far, rows[i].ctrl);
      poll_end();
      chk(q & 32'(rows[i].mask), 32'(rows[i].exp));
      if (rows[i].exp == 6'h02) begin
        wb(REG_DATA, 1'b0, 32'h0);
        chk(q, {16'h0, ARRAY});
      end
    end
    chk({31'h0, rb}, 32'h1);
    // reset in mid-poll must park the pins, then a fresh start completes
    run(3'h2, 8'hFF, 1'b0, 4'h1);
    repeat (7) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o}, 32'hE);
    wb(REG_STAT, 1'b0, 32'h0);
    chk(q, 32'h0);
    run(3'h1, 8'h04, 1'b0, 4'h1);
    poll_end();
    chk(q & 32'h6, 32'h2);
    results();
  end
endmodule
